// File: ocfg_regs.svh
// Offsets, field positions, masks and reset values of the output clock configuration registers
`ifndef OCFG_REGS_SVH
`define OCFG_REGS_SVH

`define OCFG_ADDR_W 8
`define OCFG_DATA_W 8

`define OCFG_CMOS_DRIVE_CTRL_OFS 8'h05
`define OCFG_OUTPUT_FORMAT_CTRL_OFS 8'h06
`define OCFG_OFFSET_ALARM_REF_CTRL_OFS 8'h07
`define OCFG_OUTPUT_STATIC_HOLD_CTRL_OFS 8'h08
`define OCFG_HISTORY_AVERAGE_CTRL_OFS 8'h09
`define OCFG_OUTPUT_POWERDOWN_CTRL_OFS 8'h0A

`define OCFG_CMOS_DRIVE_CTRL_RST 8'hED
`define OCFG_OUTPUT_FORMAT_CTRL_RST 8'h2D
`define OCFG_OFFSET_ALARM_REF_CTRL_RST 8'h2A
`define OCFG_OUTPUT_STATIC_HOLD_CTRL_RST 8'h00
`define OCFG_HISTORY_AVERAGE_CTRL_RST 8'hC0
`define OCFG_OUTPUT_POWERDOWN_CTRL_RST 8'h00

// Writable bits; all others are read-only at reset value
`define OCFG_CMOS_DRIVE_CTRL_WMASK 8'hC0
`define OCFG_OUTPUT_FORMAT_CTRL_WMASK 8'h3F
`define OCFG_OFFSET_ALARM_REF_CTRL_WMASK 8'h07
`define OCFG_OUTPUT_STATIC_HOLD_CTRL_WMASK 8'hF0
`define OCFG_HISTORY_AVERAGE_CTRL_WMASK 8'hF8
`define OCFG_OUTPUT_POWERDOWN_CTRL_WMASK 8'h0C

`define OCFG_CMOS_DRIVE_MSB 7
`define OCFG_CMOS_DRIVE_LSB 6
`define OCFG_OUT2_FORMAT_MSB 5
`define OCFG_OUT2_FORMAT_LSB 3
`define OCFG_OUT1_FORMAT_MSB 2
`define OCFG_OUT1_FORMAT_LSB 0
`define OCFG_REF_SEL_MSB 2
`define OCFG_REF_SEL_LSB 0
`define OCFG_OUT2_HOLD_MSB 7
`define OCFG_OUT2_HOLD_LSB 6
`define OCFG_OUT1_HOLD_MSB 5
`define OCFG_OUT1_HOLD_LSB 4
`define OCFG_HISTORY_AVG_TIME_MSB 7
`define OCFG_HISTORY_AVG_TIME_LSB 3
`define OCFG_OUT2_PD_BIT 3
`define OCFG_OUT1_PD_BIT 2

`define OCFG_UNMAPPED_RDATA 8'h00

`endif

// File: ocfg_pkg.sv
// Types of the output clock configuration register block
package ocfg_pkg;

    typedef enum logic [2:0] {
        OCFG_FMT_RSVD0 = 3'h0,
        OCFG_FMT_DISABLE = 3'h1,
        OCFG_FMT_CMOS = 3'h2,
        OCFG_FMT_LVDS_LOW = 3'h3,
        OCFG_FMT_RSVD4 = 3'h4,
        OCFG_FMT_LVPECL = 3'h5,
        OCFG_FMT_CML = 3'h6,
        OCFG_FMT_LVDS = 3'h7
    } ocfg_format_t;

    typedef enum logic [1:0] {
        OCFG_HOLD_RUN = 2'h0,
        OCFG_HOLD_LOW = 2'h1,
        OCFG_HOLD_HIGH = 2'h2,
        OCFG_HOLD_RSVD = 2'h3
    } ocfg_hold_code_t;

    typedef enum logic [2:0] {
        OCFG_REF_EXT = 3'h0,
        OCFG_REF_CLK_IN_ONE = 3'h1,
        OCFG_REF_CLK_IN_TWO = 3'h2
    } ocfg_ref_t;

    // Gray path: run -> parked_low, run -> parked_high
    typedef enum logic [1:0] {
        OCFG_ST_RUN = 2'b00,
        OCFG_ST_PARK_LOW = 2'b01,
        OCFG_ST_PARK_HIGH = 2'b10
    } ocfg_park_state_t;

    // Per-output control bundle to the buffer and low-speed divider
    typedef struct packed {
        logic [2:0] format;
        logic cmos_active;
        logic format_valid;
        logic buffer_pd;
        logic divider_pd;
    } ocfg_out_t;

    // Register access strobe with its data
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ocfg_req_t;

endpackage

// File: ocfg_regs_top.sv
// Output clock configuration registers with glitch-free static output hold
//
// Notes on behaviour
// - Bits 7:6 of the drive register set CMOS drive strength, code 00 weakest to 11 strongest.
// - Bits 5:3 of the format register pick output two format: 001 off, 010 CMOS, 011 low LVDS, 101 LVPECL, 110 CML, 111 LVDS.
// - Bits 2:0 of the format register pick output one format with the same code table.
// - The three-bit reference select picks external reference, input one or input two for offset alarms.
// - Hold bits 7:6 keep output two running at 00, park it low at 01 and high at 10.
// - Hold bits 5:4 do the same for output one.
// - Entering or leaving a parked level never makes a glitch or a short clock pulse.
// - Bits 7:3 of the averaging register set the history averaging time for digital hold.
// - Powerdown bit 3 switches off the second output buffer when set.
// - Powerdown bit 2 switches off the first output buffer when set.
// - A disabled output also has its low-speed divider powered down.
// - The drive register resets to 0xED.
// - The format register resets to 0x2D, both outputs LVPECL.
// - The reference register resets to 0x2A, input two selected.
// - The averaging register resets to 0xC0; hold and powerdown registers reset to zero.
`timescale 1ns/1ps
`include "ocfg_regs.svh"

module ocfg_regs_top
    import ocfg_pkg::*;
#(
    parameter int NUM_OUT = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register access from the serial port decoder
    input wire ocfg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Divided clocks ahead of the park logic
    input wire logic [NUM_OUT-1:0] div_clk,
    // Parked clocks toward the output buffers
    output logic [NUM_OUT-1:0] clock_out,
    // Buffer and divider controls, index 0 is output one
    output ocfg_out_t [NUM_OUT-1:0] out_cfg,
    output logic [1:0] cmos_drive_strength,
    // Offset alarm reference and history averaging
    output logic [2:0] offset_alarm_ref_sel,
    output logic offset_alarm_ref_valid,
    output logic [4:0] history_avg_time,
    // Stable-level state of each output
    output logic [NUM_OUT-1:0] out_parked
);

    logic [7:0] cmos_drive_ctrl;
    logic [7:0] output_format_ctrl;
    logic [7:0] offset_alarm_ref_ctrl;
    logic [7:0] output_static_hold_ctrl;
    logic [7:0] history_average_ctrl;
    logic [7:0] output_powerdown_ctrl;

    logic [7:0] next_rdata;
    logic [NUM_OUT-1:0][2:0] format_code;
    logic [NUM_OUT-1:0][1:0] hold_code;
    logic [NUM_OUT-1:0] pd_bit;

    // Merge written bits with fixed reserved bits
    function automatic logic [7:0] merge_wr(input logic [7:0] wdata,
                                            input logic [7:0] wmask,
                                            input logic [7:0] rst);
        merge_wr = (wdata & wmask) | (rst & ~wmask);
    endfunction

    // Register writes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmos_drive_ctrl <= `OCFG_CMOS_DRIVE_CTRL_RST;
            output_format_ctrl <= `OCFG_OUTPUT_FORMAT_CTRL_RST;
            offset_alarm_ref_ctrl <= `OCFG_OFFSET_ALARM_REF_CTRL_RST;
            output_static_hold_ctrl <= `OCFG_OUTPUT_STATIC_HOLD_CTRL_RST;
            history_average_ctrl <= `OCFG_HISTORY_AVERAGE_CTRL_RST;
            output_powerdown_ctrl <= `OCFG_OUTPUT_POWERDOWN_CTRL_RST;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `OCFG_CMOS_DRIVE_CTRL_OFS: begin
                    cmos_drive_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_CMOS_DRIVE_CTRL_WMASK, `OCFG_CMOS_DRIVE_CTRL_RST);
                end
                `OCFG_OUTPUT_FORMAT_CTRL_OFS: begin
                    output_format_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_OUTPUT_FORMAT_CTRL_WMASK, `OCFG_OUTPUT_FORMAT_CTRL_RST);
                end
                `OCFG_OFFSET_ALARM_REF_CTRL_OFS: begin
                    offset_alarm_ref_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_OFFSET_ALARM_REF_CTRL_WMASK, `OCFG_OFFSET_ALARM_REF_CTRL_RST);
                end
                `OCFG_OUTPUT_STATIC_HOLD_CTRL_OFS: begin
                    output_static_hold_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_OUTPUT_STATIC_HOLD_CTRL_WMASK, `OCFG_OUTPUT_STATIC_HOLD_CTRL_RST);
                end
                `OCFG_HISTORY_AVERAGE_CTRL_OFS: begin
                    history_average_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_HISTORY_AVERAGE_CTRL_WMASK, `OCFG_HISTORY_AVERAGE_CTRL_RST);
                end
                `OCFG_OUTPUT_POWERDOWN_CTRL_OFS: begin
                    output_powerdown_ctrl <= merge_wr(reg_req.wdata,
                        `OCFG_OUTPUT_POWERDOWN_CTRL_WMASK, `OCFG_OUTPUT_POWERDOWN_CTRL_RST);
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux
    always_comb begin
        case (reg_req.addr)
            `OCFG_CMOS_DRIVE_CTRL_OFS: next_rdata = cmos_drive_ctrl;
            `OCFG_OUTPUT_FORMAT_CTRL_OFS: next_rdata = output_format_ctrl;
            `OCFG_OFFSET_ALARM_REF_CTRL_OFS: next_rdata = offset_alarm_ref_ctrl;
            `OCFG_OUTPUT_STATIC_HOLD_CTRL_OFS: next_rdata = output_static_hold_ctrl;
            `OCFG_HISTORY_AVERAGE_CTRL_OFS: next_rdata = history_average_ctrl;
            `OCFG_OUTPUT_POWERDOWN_CTRL_OFS: next_rdata = output_powerdown_ctrl;
            default: next_rdata = `OCFG_UNMAPPED_RDATA;
        endcase
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Field extraction
    assign cmos_drive_strength =
        cmos_drive_ctrl[`OCFG_CMOS_DRIVE_MSB:`OCFG_CMOS_DRIVE_LSB];
    assign format_code[1] =
        output_format_ctrl[`OCFG_OUT2_FORMAT_MSB:`OCFG_OUT2_FORMAT_LSB];
    assign format_code[0] =
        output_format_ctrl[`OCFG_OUT1_FORMAT_MSB:`OCFG_OUT1_FORMAT_LSB];
    assign hold_code[1] =
        output_static_hold_ctrl[`OCFG_OUT2_HOLD_MSB:`OCFG_OUT2_HOLD_LSB];
    assign hold_code[0] =
        output_static_hold_ctrl[`OCFG_OUT1_HOLD_MSB:`OCFG_OUT1_HOLD_LSB];
    assign pd_bit[1] = output_powerdown_ctrl[`OCFG_OUT2_PD_BIT];
    assign pd_bit[0] = output_powerdown_ctrl[`OCFG_OUT1_PD_BIT];
    assign history_avg_time =
        history_average_ctrl[`OCFG_HISTORY_AVG_TIME_MSB:`OCFG_HISTORY_AVG_TIME_LSB];
    assign offset_alarm_ref_sel =
        offset_alarm_ref_ctrl[`OCFG_REF_SEL_MSB:`OCFG_REF_SEL_LSB];

    // Reference code check, reserved codes flagged
    always_comb begin
        case (offset_alarm_ref_sel)
            OCFG_REF_EXT,
            OCFG_REF_CLK_IN_ONE,
            OCFG_REF_CLK_IN_TWO: offset_alarm_ref_valid = 1'b1;
            default: offset_alarm_ref_valid = 1'b0;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_out
            ocfg_park_state_t park_state;
            ocfg_park_state_t next_park_state;
            logic disabled;
            logic fmt_valid;
            logic next_clk;

            always_comb begin
                case (ocfg_format_t'(format_code[gi]))
                    OCFG_FMT_RSVD0,
                    OCFG_FMT_RSVD4: fmt_valid = 1'b0;
                    default: fmt_valid = 1'b1;
                endcase
            end

            // Buffer off by powerdown bit or disable format
            assign disabled = pd_bit[gi] ||
                (ocfg_format_t'(format_code[gi]) == OCFG_FMT_DISABLE);

            always_comb begin
                out_cfg[gi].format = format_code[gi];
                out_cfg[gi].cmos_active =
                    (ocfg_format_t'(format_code[gi]) == OCFG_FMT_CMOS);
                out_cfg[gi].format_valid = fmt_valid;
                out_cfg[gi].buffer_pd = disabled;
                out_cfg[gi].divider_pd = disabled;
            end

            // Park transitions only at matching clock level
            always_comb begin
                next_park_state = park_state;
                case (park_state)
                    OCFG_ST_RUN: begin
                        if (hold_code[gi] == OCFG_HOLD_LOW && !div_clk[gi]) begin
                            next_park_state = OCFG_ST_PARK_LOW;
                        end else if (hold_code[gi] == OCFG_HOLD_HIGH && div_clk[gi]) begin
                            next_park_state = OCFG_ST_PARK_HIGH;
                        end
                    end
                    OCFG_ST_PARK_LOW: begin
                        if (hold_code[gi] != OCFG_HOLD_LOW && !div_clk[gi]) begin
                            next_park_state = OCFG_ST_RUN;
                        end
                    end
                    OCFG_ST_PARK_HIGH: begin
                        if (hold_code[gi] != OCFG_HOLD_HIGH && div_clk[gi]) begin
                            next_park_state = OCFG_ST_RUN;
                        end
                    end
                    default: next_park_state = OCFG_ST_RUN;
                endcase
            end

            always_comb begin
                case (next_park_state)
                    OCFG_ST_PARK_LOW: next_clk = 1'b0;
                    OCFG_ST_PARK_HIGH: next_clk = 1'b1;
                    default: next_clk = div_clk[gi];
                endcase
            end

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    park_state <= OCFG_ST_RUN;
                end else begin
                    park_state <= next_park_state;
                end
            end

            // Buffer output low while powered down
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    clock_out[gi] <= 1'b0;
                end else begin
                    clock_out[gi] <= next_clk && !disabled;
                end
            end

            assign out_parked[gi] = (park_state != OCFG_ST_RUN);
        end
    endgenerate

endmodule

// File: ocfg_regs_chk.sv
// Checker of register fields and output park behaviour at the top ports
`timescale 1ns/1ps
module ocfg_regs_chk
    import ocfg_pkg::*;
#(
    parameter int NUM_OUT = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire ocfg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Clock path
    input wire logic [NUM_OUT-1:0] div_clk,
    input wire logic [NUM_OUT-1:0] clock_out,
    input wire logic [NUM_OUT-1:0] out_parked,
    // Field outputs
    input wire ocfg_out_t [NUM_OUT-1:0] out_cfg,
    input wire logic [1:0] cmos_drive_strength,
    input wire logic [2:0] offset_alarm_ref_sel,
    input wire logic offset_alarm_ref_valid,
    input wire logic [4:0] history_avg_time
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence wr_at(logic [7:0] a);
        reg_req.wr && reg_req.addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    // Every output edge repeats an edge of its source while the buffer is on
    property follows_src(int i);
        $past(rstn, 2) && !out_cfg[i].buffer_pd && $past(!out_cfg[i].buffer_pd)
            && $past(!out_cfg[i].buffer_pd, 2) && $changed(clock_out[i])
            |-> clock_out[i] == $past(div_clk[i]) && $past(clock_out[i]) == $past(div_clk[i], 2);
    endproperty
    property park_holds(int i);
        out_parked[i] && $past(out_parked[i]) |-> $stable(clock_out[i]);
    endproperty
    drive_write_a: assert property (wr_at(8'h05) |=>
        cmos_drive_strength == $past(reg_req.wdata[7:6])) else $error("drive field wrong");
    fmt_write_a: assert property (wr_at(8'h06) |=>
        {out_cfg[1].format, out_cfg[0].format} == $past(reg_req.wdata[5:0]))
        else $error("format fields wrong");
    ref_write_a: assert property (wr_at(8'h07) |=> offset_alarm_ref_sel ==
        $past(reg_req.wdata[2:0]) && offset_alarm_ref_valid == ($past(reg_req.wdata[2:0]) < 3'h3))
        else $error("reference select wrong");
    avg_write_a: assert property (wr_at(8'h09) |=>
        history_avg_time == $past(reg_req.wdata[7:3])) else $error("averaging field wrong");
    pd_write_a: assert property (wr_at(8'h0A) |=>
        out_cfg[1].buffer_pd == ($past(reg_req.wdata[3]) || out_cfg[1].format == 3'h1)
        && out_cfg[0].buffer_pd == ($past(reg_req.wdata[2]) || out_cfg[0].format == 3'h1))
        else $error("buffer powerdown wrong");
    div_pd_a: assert property (out_cfg[0].divider_pd == out_cfg[0].buffer_pd
        && out_cfg[1].divider_pd == out_cfg[1].buffer_pd) else $error("divider powerdown wrong");
    edge_one_a: assert property (follows_src(0)) else $error("output one glitch");
    edge_two_a: assert property (follows_src(1)) else $error("output two glitch");
    park_one_a: assert property (park_holds(0)) else $error("output one moved");
    park_two_a: assert property (park_holds(1)) else $error("output two moved");
    rsvd_read_a: assert property (rd_at(8'h05) |=> reg_rvalid
        && reg_rdata[5:0] == 6'h2D) else $error("reserved bits wrong");
endmodule

bind ocfg_regs_top ocfg_regs_chk #(.NUM_OUT(NUM_OUT)) u_chk (.clock, .rstn, .reg_req,
    .reg_rdata, .reg_rvalid, .div_clk, .clock_out, .out_parked, .out_cfg,
    .cmos_drive_strength, .offset_alarm_ref_sel, .offset_alarm_ref_valid, .history_avg_time);

// File: ocfg_host_model.sv
// Host model issuing register writes and reads to the block
`timescale 1ns/1ps
module ocfg_host_model
    import ocfg_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output ocfg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1;
        req = '0;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clock);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1;
        req = '0;
        ok = rvalid;
        d = rdata;
    endtask
endmodule

// File: test_output_clock_config_regs.sv
// Self-checking bench of the output clock configuration registers
`timescale 1ns/1ps
module test_output_clock_config_regs
    import ocfg_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] div_clk = 2'b00;
    ocfg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [1:0] clock_out;
    logic [1:0] out_parked;
    ocfg_out_t [1:0] out_cfg;
    logic [1:0] cmos_drive_strength;
    logic [2:0] offset_alarm_ref_sel;
    logic offset_alarm_ref_valid;
    logic [4:0] history_avg_time;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int dcnt = 0;
    logic [7:0] rd_val;
    logic rd_ok;
    // Offsets, reset values and writable bits in register order
    logic [7:0] ofs [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
    logic [7:0] rst [6] = '{8'hED, 8'h2D, 8'h2A, 8'h00, 8'hC0, 8'h00};
    logic [7:0] wmsk [6] = '{8'hC0, 8'h3F, 8'h07, 8'hF0, 8'hF8, 8'h0C};

    ocfg_regs_top #(.NUM_OUT(2)) dut (.clock, .rstn, .reg_req, .reg_rdata, .reg_rvalid,
        .div_clk, .clock_out, .out_cfg, .cmos_drive_strength, .offset_alarm_ref_sel,
        .offset_alarm_ref_valid, .history_avg_time, .out_parked);
    ocfg_host_model host (.clock, .req(reg_req), .rdata(reg_rdata), .rvalid(reg_rvalid));

    initial begin
        forever #20 clock = ~clock;
    end
    // Divided clocks of period 4 and 6
    always @(posedge clock) begin
        #1;
        dcnt = dcnt + 1;
        div_clk = {(dcnt % 6) < 3, dcnt[1]};
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read(a, rd_val, rd_ok);
        check({7'h00, rd_ok}, 8'h01);
        check(rd_val, exp);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd_chk(ofs[i], rst[i]);
        end
        check({6'h00, cmos_drive_strength}, 8'h03);
        check({2'h0, out_cfg[1].format, out_cfg[0].format}, 8'h2D);
        check({5'h00, offset_alarm_ref_sel}, 8'h02);
        check({1'b0, history_avg_time, out_parked}, 8'h60);
    endtask
    task automatic t_access();
        for (int i = 0; i < 6; i++) begin
            host.write(ofs[i], 8'hFF);
            rd_chk(ofs[i], rst[i] | wmsk[i]);
            host.write(ofs[i], 8'h00);
            rd_chk(ofs[i], rst[i] & ~wmsk[i]);
        end
        host.write(8'h0B, 8'hFF);
        rd_chk(8'h0B, 8'h00);
    endtask
    task automatic t_fields();
        for (int c = 0; c < 8; c++) begin
            host.write(8'h06, {2'b00, c[2:0], c[2:0]});
            check({2'h0, out_cfg[1].format, out_cfg[0].format}, {2'b00, c[2:0], c[2:0]});
            check({6'h00, out_cfg[1].buffer_pd, out_cfg[0].divider_pd}, {6'h00, {2{c == 1}}});
            check({4'h0, out_cfg[1].cmos_active, out_cfg[1].format_valid, out_cfg[0].cmos_active,
                out_cfg[0].format_valid}, {4'h0, {2{c == 2, c != 0 && c != 4}}});
            host.write(8'h07, {5'h00, c[2:0]});
            check({4'h0, offset_alarm_ref_valid, offset_alarm_ref_sel}, {4'h0, c < 3, c[2:0]});
            host.write(8'h05, {c[1:0], 6'h00});
            check({6'h00, cmos_drive_strength}, {6'h00, c[1:0]});
            host.write(8'h09, {c[2:0], c[1:0], 3'h0});
            check({3'h0, history_avg_time}, {3'h0, c[2:0], c[1:0]});
        end
    endtask
    task automatic t_pd();
        host.write(8'h06, 8'h2D);
        for (int p = 0; p < 4; p++) begin
            host.write(8'h0A, {4'h0, p[1:0], 2'b00});
            repeat (2) @(posedge clock);
            #2;
            check({4'h0, out_cfg[1].buffer_pd, out_cfg[1].divider_pd, out_cfg[0].buffer_pd,
                out_cfg[0].divider_pd}, {4'h0, {2{p[1]}}, {2{p[0]}}});
            check({6'h00, clock_out & p[1:0]}, 8'h00);
        end
        host.write(8'h0A, 8'h00);
    endtask
    task automatic t_hold();
        logic [1:0] seen;
        logic prev;
        for (int k = 0; k < 4; k++) begin
            host.write(8'h08, 8'h10 << k);
            repeat (8) @(posedge clock);
            seen = 2'b00;
            repeat (12) begin
                @(posedge clock);
                #2;
                seen = seen | (2'b01 << clock_out[k / 2]);
                check({7'h00, out_parked[k / 2]}, 8'h01);
            end
            check({6'h00, seen}, {6'h00, 2'b01 << k[0]});
            host.write(8'h08, 8'h00);
            repeat (8) @(posedge clock);
            #2;
            prev = div_clk[k / 2];
            seen = 2'b00;
            repeat (12) begin
                @(posedge clock);
                #2;
                seen = seen | (2'b01 << clock_out[k / 2]);
                check({7'h00, clock_out[k / 2]}, {7'h00, prev});
                prev = div_clk[k / 2];
            end
            check({4'h0, seen, out_parked}, 8'h0C);
        end
    endtask
    // Reset in mid-run brings back every reset value and unparks
    task automatic t_rerst();
        host.write(8'h05, 8'h00);
        host.write(8'h08, 8'h10);
        repeat (8) @(posedge clock);
        #1;
        rstn = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        rstn = 1'b1;
        t_reset();
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1;
        rstn = 1'b1;
        t_reset();
        t_access();
        t_fields();
        t_pd();
        t_hold();
        t_rerst();
        tally_and_finish();
    end
endmodule
